// ===== axil_port.v
// axi4-lite slave front end: turns bus beats into one-cycle register strobes
// assumes the register file decodes addresses and answers ok/error at once
`timescale 1ns/1ns
`include "pwm_defs.vh"
module axil_port (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // write address and data
  input wire [7:0] awaddr_i,
  input wire awvalid_i,
  output reg awready_o,
  input wire [31:0] wdata_i,
  input wire [3:0] wstrb_i,
  input wire wvalid_i,
  output reg wready_o,
  // write response
  output reg [1:0] bresp_o,
  output reg bvalid_o,
  input wire bready_i,
  // read
  input wire [7:0] araddr_i,
  input wire arvalid_i,
  output reg arready_o,
  output reg [31:0] rdata_o,
  output reg [1:0] rresp_o,
  output reg rvalid_o,
  input wire rready_i,
  // register side
  output wire wr_en_o,
  output wire [7:0] wr_addr_o,
  output wire [31:0] wr_data_o,
  output wire [3:0] wr_strb_o,
  input wire wr_ok_i,
  output wire [7:0] rd_addr_o,
  input wire [31:0] rd_data_i,
  input wire rd_ok_i
);
  reg aw_got;
  reg w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // write fires once both halves are held and no response is pending
  assign wr_en_o = aw_got & w_got & ~bvalid_o;
  assign wr_addr_o = aw_addr;
  assign wr_data_o = w_data;
  assign wr_strb_o = w_strb;
  assign rd_addr_o = araddr_i;

  // write channels, taken in either order
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= `RST_WORD;
      w_strb <= 4'h0;
      bvalid_o <= 1'b0;
      bresp_o <= `RESP_OKAY;
    end else begin
      if (awvalid_i & awready_o) begin
        aw_got <= 1'b1;
        awready_o <= 1'b0;
        aw_addr <= awaddr_i;
      end
      if (wvalid_i & wready_o) begin
        w_got <= 1'b1;
        wready_o <= 1'b0;
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end
      if (wr_en_o) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= wr_ok_i ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_o & bready_i) begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
    end
  end

  // read: data captured in the accepting cycle, one read in flight
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= `RST_WORD;
      rresp_o <= `RESP_OKAY;
    end else begin
      if (arvalid_i & arready_o) begin
        arready_o <= 1'b0;
        rvalid_o <= 1'b1;
        rdata_o <= rd_data_i;
        rresp_o <= rd_ok_i ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid_o & rready_i) begin
        rvalid_o <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end
endmodule

// ===== enhanced_pwm_power_reset_behaviour_tb.sv
// self-checking bench: bus master, oscillator tick pins, power modes and faults
// assumes pwm_defs.vh on the include path and the checker bound to the unit
`timescale 1ns/1ns
`include "pwm_defs.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module enhanced_pwm_power_reset_behaviour_tb;
  reg mclk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg [7:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0;
  reg [3:0] wstrb = 0;
  reg [1:0] pm_mode = 0, c3 = 0;
  reg alt_tick = 0, int_tick = 0, clk_fail = 0, fault_n = 1, ph = 0, cmp1 = 0, cmp2 = 0;
  wire awready, wready, bvalid, arready, rvalid, osc_fail, int_mode;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] pwm_out, pwm_oe_n, pin;
  integer fail_count = 0, check_count = 0, k;
  reg [7:0] r, src;
  reg [3:0] lvl;
  reg [33:0] rexp_q[$];
  reg [1:0] bexp_q[$];

  // reduced variant so the unimplemented bits can be seen reading zero
  pwm_power_unit #(.REDUCED_PINS(1)) DUT (.MCLK_I(mclk), .NRST_I(nrst),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
    .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
    .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
    .RREADY_I(rready), .PM_MODE_I(pm_mode), .ALT_TICK_I(alt_tick),
    .INT_OSC_TICK_I(int_tick), .CLK_FAIL_I(clk_fail), .FAULT_N_I(fault_n),
    .CMP1_I(cmp1), .CMP2_I(cmp2), .PWM_OUT_O(pwm_out), .PWM_OE_N_O(pwm_oe_n),
    .OSC_FAIL_O(osc_fail), .INT_MODE_O(int_mode));
  switch_model sw (.pwm_out_i(pwm_out), .pwm_oe_n_i(pwm_oe_n), .level_o(pin));

  initial begin
    forever #25 mclk = ~mclk;
  end
  // alternate ticks rise every 4 clocks, internal ones every 6
  always @(posedge mclk) begin
    ph <= ~ph;
    if (ph) alt_tick <= ~alt_tick;
    c3 <= (c3 == 2'd2) ? 2'd0 : c3 + 2'd1;
    if (c3 == 2'd2) int_tick <= ~int_tick;
  end
  // oldest note is compared whenever an answer is handed over
  always @(posedge mclk) begin
    if (rvalid && rready) begin
      `CHK("rdata", rexp_q[0][31:0], rdata)
      `CHK("rresp", rexp_q[0][33:32], rresp)
      void'(rexp_q.pop_front());
    end
    if (bvalid && bready) begin
      `CHK("bresp", bexp_q[0], bresp)
      void'(bexp_q.pop_front());
    end
  end

  task final_report;
    begin
      if (fail_count == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task wr(input [7:0] a, input [7:0] d, input [3:0] s, input [1:0] e);
    integer i;
    begin
      bexp_q.push_back(e);
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
        @(posedge mclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) break;
      end
      bready <= 1'b0;
      // one edge between calls, so the next call never rewrites bready in this step
      @(posedge mclk);
      if (i == 50) begin fail_count++; final_report; end
    end
  endtask
  task rd(input [7:0] a, input [31:0] d, input [1:0] e);
    integer i;
    begin
      rexp_q.push_back({e, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
        @(posedge mclk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) break;
      end
      rready <= 1'b0;
      @(posedge mclk);
      if (i == 50) begin fail_count++; final_report; end
    end
  endtask
  // counts high cycles of pin a over a whole number of pwm periods
  task cnt(input integer n, input integer e);
    integer i, h;
    begin
      h = 0;
      for (i = 0; i < n; i++) begin @(posedge mclk); h += pin[0]; end
      `CHK("pin a highs", e, h)
    end
  endtask

  initial begin
    #(50 * 90000);
    fail_count++;
    final_report;
  end
  initial begin
    void'($urandom(19));
    tick(10);
    nrst <= 1'b1;
    tick(2);
    for (k = 0; k <= 10; k++) rd(8'(k * 4), (k == 8) ? 32'h0000_000F : 32'h0, `RESP_OKAY);
    rd(8'h40, 32'h0, `RESP_SLVERR);
    wr(8'h40, 8'h55, 4'hF, `RESP_SLVERR);
    r = 8'($urandom_range(255, 1));
    wr(`OFS_PERIOD, r, 4'hF, `RESP_OKAY);
    wr(`OFS_PERIOD, ~r, 4'h0, `RESP_OKAY);
    rd(`OFS_PERIOD, {24'h00_0000, r}, `RESP_OKAY);
    wr(`OFS_SHUT_CTL, 8'h0F, 4'hF, `RESP_OKAY);
    rd(`OFS_SHUT_CTL, 32'h0000_000C, `RESP_OKAY);
    wr(`OFS_RESTART, 8'h7F, 4'hF, `RESP_OKAY);
    rd(`OFS_RESTART, 32'h0, `RESP_OKAY);
    // 16 ticks a period, pin a high for 8 of them
    wr(`OFS_SHUT_CTL, 8'h00, 4'hF, `RESP_OKAY);
    wr(`OFS_PERIOD, 8'h03, 4'hF, `RESP_OKAY);
    wr(`OFS_DUTY_LO, 8'h02, 4'hF, `RESP_OKAY);
    wr(`OFS_PWM_CTL, 8'h0C, 4'hF, `RESP_OKAY);
    wr(`OFS_TMR_CTL, 8'h04, 4'hF, `RESP_OKAY);
    wr(`OFS_PIN_DIR, 8'h00, 4'hF, `RESP_OKAY);
    tick(64);
    cnt(160, 80);
    pm_mode <= `PM_PRIM_IDLE;
    tick(32);
    cnt(160, 80);
    pm_mode <= `PM_ALT;
    tick(128);
    cnt(640, 320);
    pm_mode <= `PM_SLEEP;
    tick(4);
    lvl = pin;
    tick(100);
    `CHK("sleep pins", lvl, pin)
    pm_mode <= `PM_RUN;
    tick(32);
    cnt(160, 80);
    // primary clock fails: internal ticks take over the timing
    wr(`OFS_SYS_CFG, 8'h01, 4'hF, `RESP_OKAY);
    clk_fail <= 1'b1;
    for (k = 0; k < 20 && int_mode !== 1'b1; k++) @(posedge mclk);
    `CHK("fail flag", 1'b1, osc_fail)
    `CHK("internal mode", 1'b1, int_mode)
    tick(192);
    cnt(960, 480);
    clk_fail <= 1'b0;
    tick(4);
    wr(`OFS_PFR2, 8'h80, 4'hF, `RESP_OKAY);
    tick(4);
    `CHK("internal mode", 1'b0, int_mode)
    // fail flag cleared, period flag still set by the running timer
    rd(`OFS_PFR2, 32'h0000_0002, `RESP_OKAY);
    // fault, then comparator 2, then comparator 1; only the first restarts itself
    wr(`OFS_RESTART, 8'h80, 4'hF, `RESP_OKAY);
    for (k = 0; k < 3; k++) begin
      src = 8'h40 >> k;
      wr(`OFS_SHUT_CTL, src, 4'hF, `RESP_OKAY);
      fault_n <= (k != 0);
      cmp2 <= (k == 1);
      cmp1 <= (k == 2);
      tick(6);
      rd(`OFS_SHUT_CTL, {24'h00_0000, 8'h80 | src}, `RESP_OKAY);
      fault_n <= 1'b1;
      cmp2 <= 1'b0;
      cmp1 <= 1'b0;
      tick(6);
      rd(`OFS_SHUT_CTL, {24'h00_0000, (k == 0) ? src : 8'h80 | src}, `RESP_OKAY);
      wr(`OFS_RESTART, 8'h00, 4'hF, `RESP_OKAY);
    end
    nrst <= 1'b0;
    tick(2);
    `CHK("pin enables", 4'hF, pwm_oe_n)
    `CHK("pin levels", 4'h0, pwm_out)
    nrst <= 1'b1;
    tick(2);
    rd(`OFS_SHUT_CTL, 32'h0, `RESP_OKAY);
    rd(`OFS_PIN_DIR, 32'h0000_000F, `RESP_OKAY);
    tick(2);
    final_report;
  end
endmodule

// ===== pwm_defs.vh
// constants shared by the pwm unit, its bus port and its testbench
// assumes byte addressing on a 32-bit register bus, one word per register
`ifndef PWM_DEFS_VH
`define PWM_DEFS_VH
// register offsets, byte addresses
`define OFS_TMR_CNT 8'h00
`define OFS_TMR_CTL 8'h04
`define OFS_PERIOD 8'h08
`define OFS_DUTY_LO 8'h0C
`define OFS_DUTY_HI 8'h10
`define OFS_PWM_CTL 8'h14
`define OFS_SHUT_CTL 8'h18
`define OFS_RESTART 8'h1C
`define OFS_PIN_DIR 8'h20
`define OFS_SYS_CFG 8'h24
`define OFS_PFR2 8'h28
// field positions
`define TMR_ON_BIT 2
`define SD_STATUS_BIT 7
`define RESTART_EN_BIT 7
`define OSC_FAIL_BIT 7
`define PERIOD_FLAG_BIT 1
`define INT_MODE_BIT 0
`define FAIL_MON_BIT 0
// reset values
`define RST_REG8 8'h00
`define RST_DIR 4'hF
`define RST_WORD 32'h0000_0000
// power-managed mode codes
`define PM_RUN 2'b00
`define PM_PRIM_IDLE 2'b01
`define PM_ALT 2'b10
`define PM_SLEEP 2'b11
// oscillator periods per instruction cycle is four: quarter counter wraps here
`define Q_LAST 2'b11
// prescaler terminal counts for divide by 1, 4 and 16
`define PRE_LIM_1 4'h0
`define PRE_LIM_4 4'h3
`define PRE_LIM_16 4'hF
// bus responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ===== pwm_power_monitor.sv
// checker for the pwm unit: bus answer timing, sleep freeze, failover and reset
// assumes it is bound to pwm_power_unit and sees only that module's ports
`timescale 1ns/1ns
module pwm_power_monitor (
  // clock and reset
  input wire MCLK_I,
  input wire NRST_I,
  // bus handshake
  input wire AWVALID_I,
  input wire AWREADY_O,
  input wire WVALID_I,
  input wire WREADY_O,
  input wire [1:0] BRESP_O,
  input wire BVALID_O,
  input wire BREADY_I,
  input wire ARVALID_I,
  input wire ARREADY_O,
  input wire [31:0] RDATA_O,
  input wire RVALID_O,
  input wire RREADY_I,
  // power mode, pins and status
  input wire [1:0] PM_MODE_I,
  input wire [3:0] PWM_OUT_O,
  input wire [3:0] PWM_OE_N_O,
  input wire OSC_FAIL_O,
  input wire INT_MODE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);

  // reset is the antecedent here, so this one must not be disabled by it
  property p_reset_pins;
    disable iff (1'b0) !NRST_I |=> PWM_OE_N_O == 4'hF && PWM_OUT_O == 4'h0 && !OSC_FAIL_O;
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins not released by reset");
  // no tick in sleep, so nothing at the pins may move
  property p_sleep_level;
    PM_MODE_I == 2'b11 |=> $stable(PWM_OUT_O);
  endproperty
  a_sleep_level: assert property (p_sleep_level) else $error("pin level moved in sleep");
  property p_sleep_drive;
    PM_MODE_I == 2'b11 ##1 PM_MODE_I == 2'b11 |-> $stable(PWM_OE_N_O) && $stable(PWM_OUT_O);
  endproperty
  a_sleep_drive: assert property (p_sleep_drive) else $error("pin drive moved in sleep");
  property p_wr_lat;
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##[1:2] BVALID_O;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late");
  property p_b_hold;
    BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_rd_lat;
    ARVALID_I && ARREADY_O |=> RVALID_O;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_r_hold;
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_ready_low;
    $rose(BVALID_O) |-> !AWREADY_O && !WREADY_O;
  endproperty
  a_ready_low: assert property (p_ready_low) else $error("second write accepted early");
  property p_fail_mode;
    $rose(OSC_FAIL_O) |-> ##[0:2] INT_MODE_O;
  endproperty
  a_fail_mode: assert property (p_fail_mode) else $error("no internal mode on fail");
endmodule

bind pwm_power_unit pwm_power_monitor mon (.MCLK_I, .NRST_I, .AWVALID_I, .AWREADY_O,
  .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARVALID_I, .ARREADY_O,
  .RDATA_O, .RVALID_O, .RREADY_I, .PM_MODE_I, .PWM_OUT_O, .PWM_OE_N_O, .OSC_FAIL_O,
  .INT_MODE_O);

// ===== pwm_power_unit.v
// enhanced pwm unit with power-mode clocking, clock-fail switchover and reset
// assumes PM_MODE_I and the bus inputs come from logic on MCLK_I; all other
// inputs are pins and are synchronised; oscillator ticks arrive as pin levels
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "pwm_defs.vh"
module pwm_power_unit #(
  parameter REDUCED_PINS = 0
) (
  // clock and reset
  input wire MCLK_I,
  input wire NRST_I,
  // axi4-lite write
  input wire [7:0] AWADDR_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output wire WREADY_O,
  output wire [1:0] BRESP_O,
  output wire BVALID_O,
  input wire BREADY_I,
  // axi4-lite read
  input wire [7:0] ARADDR_I,
  input wire ARVALID_I,
  output wire ARREADY_O,
  output wire [31:0] RDATA_O,
  output wire [1:0] RRESP_O,
  output wire RVALID_O,
  input wire RREADY_I,
  // power management and clock sources
  input wire [1:0] PM_MODE_I,
  input wire ALT_TICK_I,
  input wire INT_OSC_TICK_I,
  input wire CLK_FAIL_I,
  // shutdown sources
  input wire FAULT_N_I,
  input wire CMP1_I,
  input wire CMP2_I,
  // pwm pins a..d
  output reg [3:0] PWM_OUT_O,
  output reg [3:0] PWM_OE_N_O,
  // status
  output reg OSC_FAIL_O,
  output reg INT_MODE_O
);
  wire wr_en;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire [7:0] rd_addr;
  reg [31:0] rd_data;
  reg rd_ok;
  reg wr_ok;
  wire [5:0] pin_s;

  reg [7:0] tmr;
  reg [6:0] tmr_ctl;
  reg [7:0] period;
  reg [7:0] duty_lo;
  reg [7:0] duty_hi;
  reg [7:0] pwm_ctl;
  reg [7:0] shut_ctl;
  reg [7:0] restart_cfg;
  reg [3:0] pin_dir;
  reg fail_mon;
  reg per_flag;
  reg [1:0] qcnt;
  reg [1:0] duty_frac;
  reg [3:0] pre;
  reg [3:0] post;
  reg [6:0] dly;
  reg act;
  reg shut_eff;
  reg alt_q;
  reg osc_q;
  reg [3:0] pre_lim;
  reg [3:0] base;

  axil_port u_bus (
    .clk_i(MCLK_I),
    .rst_n_i(NRST_I),
    .awaddr_i(AWADDR_I),
    .awvalid_i(AWVALID_I),
    .awready_o(AWREADY_O),
    .wdata_i(WDATA_I),
    .wstrb_i(WSTRB_I),
    .wvalid_i(WVALID_I),
    .wready_o(WREADY_O),
    .bresp_o(BRESP_O),
    .bvalid_o(BVALID_O),
    .bready_i(BREADY_I),
    .araddr_i(ARADDR_I),
    .arvalid_i(ARVALID_I),
    .arready_o(ARREADY_O),
    .rdata_o(RDATA_O),
    .rresp_o(RRESP_O),
    .rvalid_o(RVALID_O),
    .rready_i(RREADY_I),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_ok_i(wr_ok),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_ok_i(rd_ok)
  );

  // pin levels: alt tick, internal tick, fail, fault, cmp1, cmp2
  sync2 #(.WIDTH(6)) u_sync (
    .clk_i(MCLK_I),
    .rst_n_i(NRST_I),
    .d_i({ALT_TICK_I, INT_OSC_TICK_I, CLK_FAIL_I, ~FAULT_N_I, CMP1_I, CMP2_I}),
    .q_o(pin_s)
  );

  // byte lane 0 carries every register
  wire we = wr_en & wr_strb[0];
  wire [6:0] pdc = (REDUCED_PINS != 0) ? 7'h00 : restart_cfg[6:0];
  wire [1:0] pss_bd = (REDUCED_PINS != 0) ? 2'b00 : shut_ctl[1:0];

  // clock source choice, expressed as a per-oscillator-period tick
  wire alt_edge = pin_s[5] & ~alt_q;
  wire int_edge = pin_s[4] & ~osc_q;
  wire sleep = (PM_MODE_I == `PM_SLEEP);
  wire alt_mode = (PM_MODE_I == `PM_ALT);
  wire tick = sleep ? 1'b0 :
    INT_MODE_O ? int_edge :
    alt_mode ? alt_edge :
    1'b1; // run and primary idle both use every primary edge

  // instruction cycle is four oscillator ticks
  wire icyc = tick & (qcnt == `Q_LAST);
  wire tmr_on = tmr_ctl[`TMR_ON_BIT];
  wire inc = icyc & tmr_on & (pre == pre_lim);
  wire match = inc & (tmr == period);
  wire pwm_en = (pwm_ctl[3:2] == 2'b11);
  wire raw = pwm_en & ({tmr, qcnt} < {duty_hi, duty_frac});
  wire fail_evt = fail_mon & pin_s[3] & ~INT_MODE_O;
  wire shut_cond = (shut_ctl[6] & pin_s[2]) | (shut_ctl[5] & pin_s[0]) |
    (shut_ctl[4] & pin_s[1]);
  wire clr_pfr = we & (wr_addr == `OFS_PFR2);

  // prescaler terminal count
  always @* begin
    case (tmr_ctl[1:0])
      2'b00: pre_lim = `PRE_LIM_1;
      2'b01: pre_lim = `PRE_LIM_4;
      default: pre_lim = `PRE_LIM_16;
    endcase
  end

  // tick edge history; runs free so a wake-up sees fresh edges only
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      alt_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      alt_q <= pin_s[5];
      osc_q <= pin_s[4];
    end
  end

  // software-owned configuration
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      tmr_ctl <= 7'h00;
      period <= `RST_REG8;
      duty_lo <= `RST_REG8;
      pwm_ctl <= `RST_REG8;
      restart_cfg <= `RST_REG8;
      pin_dir <= `RST_DIR;
      fail_mon <= 1'b0;
    end else if (we) begin
      if (wr_addr == `OFS_TMR_CTL) begin
        tmr_ctl <= wr_data[6:0];
      end else if (wr_addr == `OFS_PERIOD) begin
        period <= wr_data[7:0];
      end else if (wr_addr == `OFS_DUTY_LO) begin
        duty_lo <= wr_data[7:0];
      end else if (wr_addr == `OFS_PWM_CTL) begin
        pwm_ctl <= wr_data[7:0];
      end else if (wr_addr == `OFS_RESTART) begin
        restart_cfg <= wr_data[7:0];
      end else if (wr_addr == `OFS_PIN_DIR) begin
        pin_dir <= wr_data[3:0];
      end else if (wr_addr == `OFS_SYS_CFG) begin
        fail_mon <= wr_data[`FAIL_MON_BIT];
      end
    end
  end

  // period timer, prescaler, postscaler and duty reload, all under tick
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      tmr <= `RST_REG8;
      duty_hi <= `RST_REG8;
      duty_frac <= 2'b00;
      qcnt <= 2'b00;
      pre <= 4'h0;
      post <= 4'h0;
    end else begin
      if (tick) begin
        qcnt <= qcnt + 2'b01;
      end
      if (icyc & tmr_on) begin
        pre <= (pre == pre_lim) ? 4'h0 : pre + 4'h1;
      end
      if (we & (wr_addr == `OFS_TMR_CNT)) begin
        tmr <= wr_data[7:0];
      end else if (inc) begin
        tmr <= match ? 8'h00 : tmr + 8'h01;
      end
      if (we & (wr_addr == `OFS_DUTY_HI)) begin
        duty_hi <= wr_data[7:0];
      end else if (match) begin
        duty_hi <= duty_lo; // duty_lo only takes effect at a period boundary
        duty_frac <= pwm_ctl[5:4];
      end
      if (match) begin
        post <= (post == tmr_ctl[6:3]) ? 4'h0 : post + 4'h1;
      end
    end
  end

  // active-edge delay: counted in instruction cycles after raw goes active
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      act <= 1'b0;
      dly <= 7'h00;
    end else if (tick) begin
      if (!raw) begin
        act <= 1'b0; // inactive edge is never delayed
        dly <= pdc;
      end else if (dly == 7'h00) begin
        act <= 1'b1;
      end else if (icyc) begin
        dly <= dly - 7'h01;
      end
    end
  end

  // shutdown control; a live shutdown source beats any write
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      shut_ctl <= `RST_REG8;
      shut_eff <= 1'b0;
    end else begin
      if (we & (wr_addr == `OFS_SHUT_CTL)) begin
        shut_ctl[6:0] <= wr_data[6:0];
      end
      if (shut_cond) begin
        shut_ctl[`SD_STATUS_BIT] <= 1'b1;
      end else if (we & (wr_addr == `OFS_SHUT_CTL)) begin
        shut_ctl[`SD_STATUS_BIT] <= wr_data[`SD_STATUS_BIT];
      end else if (restart_cfg[`RESTART_EN_BIT]) begin
        shut_ctl[`SD_STATUS_BIT] <= 1'b0;
      end
      // outputs leave shutdown only at the start of a period
      if (shut_ctl[`SD_STATUS_BIT]) begin
        shut_eff <= 1'b1;
      end else if (match) begin
        shut_eff <= 1'b0;
      end
    end
  end

  // clock fail monitor and flags; a set in the clearing cycle wins
  always @(posedge MCLK_I) begin
    if (!NRST_I) begin
      OSC_FAIL_O <= 1'b0;
      INT_MODE_O <= 1'b0;
      per_flag <= 1'b0;
    end else begin
      if (fail_evt) begin
        OSC_FAIL_O <= 1'b1;
      end else if (clr_pfr & wr_data[`OSC_FAIL_BIT]) begin
        OSC_FAIL_O <= 1'b0;
      end
      // stay on the internal clock until the flag is cleared and the fail is gone
      if (fail_evt) begin
        INT_MODE_O <= 1'b1;
      end else if (!OSC_FAIL_O & !pin_s[3]) begin
        INT_MODE_O <= 1'b0;
      end
      if (match & (post == tmr_ctl[6:3])) begin
        per_flag <= 1'b1;
      end else if (clr_pfr & wr_data[`PERIOD_FLAG_BIT]) begin
        per_flag <= 1'b0;
      end
    end
  end

  // steering of the modulated signal onto pins a, b, c, d
  always @* begin
    case (pwm_ctl[7:6])
      2'b00: base = {3'b000, act};
      2'b01: base = {act, 2'b00, 1'b1};
      2'b10: base = {2'b00, ~act, act};
      default: base = {1'b0, 1'b1, act, 1'b0};
    endcase
  end

  // pin registers hold whenever no tick arrives, so sleep keeps the level
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_pin
      wire inv = (i % 2 == 0) ? pwm_ctl[1] : pwm_ctl[0];
      wire [1:0] pss = (i % 2 == 0) ? shut_ctl[3:2] : pss_bd;
      always @(posedge MCLK_I) begin
        if (!NRST_I) begin
          PWM_OUT_O[i] <= 1'b0;
          PWM_OE_N_O[i] <= 1'b1;
        end else if (tick) begin
          if (shut_eff) begin
            PWM_OUT_O[i] <= pss[0];
            PWM_OE_N_O[i] <= pin_dir[i] | pss[1];
          end else begin
            PWM_OUT_O[i] <= pwm_en & (base[i] ^ inv);
            PWM_OE_N_O[i] <= pin_dir[i];
          end
        end
      end
    end
  endgenerate

  // write decode answer
  always @* begin
    if (wr_addr == `OFS_TMR_CNT || wr_addr == `OFS_TMR_CTL) begin
      wr_ok = 1'b1;
    end else if (wr_addr == `OFS_PERIOD || wr_addr == `OFS_DUTY_LO) begin
      wr_ok = 1'b1;
    end else if (wr_addr == `OFS_DUTY_HI || wr_addr == `OFS_PWM_CTL) begin
      wr_ok = 1'b1;
    end else if (wr_addr == `OFS_SHUT_CTL || wr_addr == `OFS_RESTART) begin
      wr_ok = 1'b1;
    end else if (wr_addr == `OFS_PIN_DIR || wr_addr == `OFS_SYS_CFG) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = (wr_addr == `OFS_PFR2);
    end
  end

  // read mux; unused upper bits read zero
  always @* begin
    rd_ok = 1'b1;
    rd_data = `RST_WORD;
    if (rd_addr == `OFS_TMR_CNT) begin
      rd_data[7:0] = tmr;
    end else if (rd_addr == `OFS_TMR_CTL) begin
      rd_data[6:0] = tmr_ctl;
    end else if (rd_addr == `OFS_PERIOD) begin
      rd_data[7:0] = period;
    end else if (rd_addr == `OFS_DUTY_LO) begin
      rd_data[7:0] = duty_lo;
    end else if (rd_addr == `OFS_DUTY_HI) begin
      rd_data[7:0] = duty_hi;
    end else if (rd_addr == `OFS_PWM_CTL) begin
      rd_data[7:0] = pwm_ctl;
    end else if (rd_addr == `OFS_SHUT_CTL) begin
      rd_data[7:0] = {shut_ctl[7:2], pss_bd};
    end else if (rd_addr == `OFS_RESTART) begin
      rd_data[7:0] = {restart_cfg[7], pdc};
    end else if (rd_addr == `OFS_PIN_DIR) begin
      rd_data[3:0] = pin_dir;
    end else if (rd_addr == `OFS_SYS_CFG) begin
      rd_data[`FAIL_MON_BIT] = fail_mon;
    end else if (rd_addr == `OFS_PFR2) begin
      rd_data[7:0] = {OSC_FAIL_O, 3'b000, PM_MODE_I, per_flag, INT_MODE_O};
    end else begin
      rd_ok = 1'b0;
    end
  end
endmodule

// ===== switch_model.sv
// model of the power switch drivers hanging on the four pwm pins
// assumes each pin has a pull-down holding the switch off while undriven
`timescale 1ns/1ns
module switch_model (
  // pins from the unit
  input wire [3:0] pwm_out_i,
  input wire [3:0] pwm_oe_n_i,
  // level each switch driver sees
  output wire [3:0] level_o
);
  // an undriven pin falls to the pull-down, never to the last driven value
  assign level_o = pwm_out_i & ~pwm_oe_n_i;
endmodule

// ===== sync2.v
// two-stage synchroniser for a group of unrelated pin levels
// assumes each bit is a slow level or a pulse wider than two clocks
`timescale 1ns/1ns
module sync2 #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // levels
  input wire [WIDTH-1:0] d_i,
  output reg [WIDTH-1:0] q_o
);
  reg [WIDTH-1:0] meta;

  // first stage feeds only the second
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= {WIDTH{1'b0}};
      q_o <= {WIDTH{1'b0}};
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
